//--- rtl/strap_cfg_pkg.sv
// constants, field layout and timing for the reset strap configuration latch
package strap_cfg_pkg;
	// capture register layout, one bit per strap pin
	localparam int BOOT_LSB = 0;
	localparam int BOOT_W = 4;
	localparam int FAST_POS = 4;
	localparam int PLL_LSB = 5;
	localparam int PLL_W = 3;
	localparam int AEM_LSB = 8;
	localparam int AEM_W = 3;
	localparam int CS2W_POS = 11;
	localparam int ENDIAN_POS = 12;
	localparam int PCI_POS = 13;
	localparam int CAP_W = 14;
	// shared strap pads are all capture bits below the pci bit
	localparam int PAD_W = 13;
	// bus width codes and the no-memory pinout mode code
	localparam logic WIDTH_8 = 1'h0;
	localparam logic WIDTH_16 = 1'h1;
	localparam logic [2:0] AEM_NONE = 3'h0;
	// sub-block ownership of each pad
	localparam int SUB0_LAST = 3;
	localparam int SUB1_LAST = 7;
	// timing
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int GRST_HOLD_NS = 100;
	localparam int GRST_HOLD_CYC = (GRST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [1:0] {ST_SYNC, ST_CAPTURE, ST_HOLD, ST_RUN} seq_state_e;
endpackage

//--- rtl/strap_if.sv
// carrier between the strap sampler and the sequencing top
`timescale 1ns/1ps
interface strap_if;
	import strap_cfg_pkg::*;
	logic [CAP_W-1:0] cap;
	logic capture;
	modport sampler(input capture, output cap);
	modport user(output capture, input cap);
endinterface

//--- rtl/strap_sampler.sv
// synchronises strap pins and holds the capture register
`timescale 1ns/1ps
module strap_sampler
	import strap_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [PAD_W-1:0] pad_in,
	input wire logic pci_enable_strap,
	strap_if.sampler sif
);
	logic [CAP_W-1:0] meta;
	logic [CAP_W-1:0] sync;
	logic [CAP_W-1:0] cap;

	// two-flop synchroniser, first stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			sync <= '0;
		end else begin
			meta <= {pci_enable_strap, pad_in};
			sync <= meta;
		end
	end

	// one strobe loads all straps together; no write path exists
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cap <= '0;
		end else if (sif.capture) begin
			cap <= sync;
		end
	end

	assign sif.cap = cap;
endmodule

//--- rtl/strap_cfg_latch.sv
// reset strap capture, default seeding and strap pad ownership
`timescale 1ns/1ps
module strap_cfg_latch
	import strap_cfg_pkg::*;
#(
	parameter int NUM_OTHER_CS = 3,
	parameter int HOLD_CYCLES = GRST_HOLD_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	// shared strap pads
	input wire logic [PAD_W-1:0] pad_in,
	output logic [PAD_W-1:0] pad_out,
	output logic [PAD_W-1:0] pad_oe,
	// dedicated pci enable pin
	input wire logic pci_enable_strap,
	// functional drivers of the shared pads
	input wire logic [PAD_W-1:0] gpio_out,
	input wire logic [PAD_W-1:0] gpio_oe,
	input wire logic [PAD_W-1:0] mem_out,
	input wire logic [PAD_W-1:0] mem_oe,
	// software writes
	input wire logic pinout_mode_wr,
	input wire logic [AEM_W-1:0] pinout_mode_wdata,
	input wire logic pci_field_wr,
	input wire logic pci_field_wdata,
	input wire logic cs2_width_wr,
	input wire logic cs2_width_wdata,
	input wire logic [NUM_OTHER_CS-1:0] cs_width_wr,
	input wire logic [NUM_OTHER_CS-1:0] cs_width_wdata,
	input wire logic mem_power_wr,
	input wire logic mem_power_enable_wdata,
	// state shown to software and peripherals
	output logic [CAP_W-1:0] strap_capture_reg,
	output logic [AEM_W-1:0] latched_pinout_mode,
	output logic [AEM_W-1:0] pinout_mode,
	output logic pci_enable_field,
	output logic cs2_width,
	output logic [NUM_OTHER_CS-1:0] cs_width,
	output logic held_in_soft_reset,
	output logic little_endian,
	output logic pci_pulls_enable,
	output logic host_boot_pci,
	output logic [BOOT_W-1:0] boot_mode,
	output logic fast_boot,
	output logic [PLL_W-1:0] fast_boot_pll_mult,
	output logic global_reset_done
);
	localparam int CNT_W = $clog2(HOLD_CYCLES + SYNC_STAGES + 1);
	localparam logic [CNT_W-1:0] SYNC_LAST = CNT_W'(SYNC_STAGES - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
	localparam int HOLD_DLY = HOLD_CYCLES;

	// refuse settings the sequencer cannot serve
	if (HOLD_CYCLES < 1) begin : g_bad_hold
		$error("HOLD_CYCLES must be at least one");
	end
	if (NUM_OTHER_CS < 1) begin : g_bad_cs
		$error("NUM_OTHER_CS must be at least one");
	end
	// the hold length check spells the hold out as one delay, so keep it short
	if (HOLD_CYCLES > 300) begin : g_long_hold
		$error("HOLD_CYCLES too long for the hold length check");
	end
	// the capture layout puts every shared pad below the pci bit
	if (PAD_W != CAP_W - 1) begin : g_bad_layout
		$error("PAD_W must be one less than CAP_W");
	end

	strap_if sif();

	strap_sampler u_sampler (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pad_in(pad_in),
		.pci_enable_strap(pci_enable_strap),
		.sif(sif)
	);

	// sub-block of a pad: 0, 1 or 3
	function automatic logic [1:0] sub_block_of(input int idx);
		if (idx <= SUB0_LAST) begin
			return 2'h0;
		end
		if (idx <= SUB1_LAST) begin
			return 2'h1;
		end
		return 2'h3;
	endfunction

	// mask of memory-owned sub-blocks {3, 1, 0} for a pinout mode
	function automatic logic [2:0] mem_owned_subs(input logic [AEM_W-1:0] mode);
		unique case (mode)
			3'h0: return 3'h0;
			3'h1: return 3'h1;
			3'h2: return 3'h3;
			default: return 3'h7;
		endcase
	endfunction

	seq_state_e state;
	seq_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic running;
	logic holding;
	logic sync_done;
	logic hold_done;

	assign running = (state == ST_RUN);
	assign holding = (state == ST_HOLD);
	assign sync_done = (cnt == SYNC_LAST);
	assign hold_done = (cnt == HOLD_LAST);
	// wait out the synchroniser so the capture sees settled pin levels
	assign sif.capture = (state == ST_CAPTURE);
	assign global_reset_done = running;

	// reset sequencing: settle, capture once, hold global reset, run
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			ST_SYNC: begin
				next_cnt = cnt + CNT_W'(1);
				if (sync_done) begin
					next_state = ST_CAPTURE;
					next_cnt = '0;
				end
			end
			ST_CAPTURE: begin
				next_state = ST_HOLD;
			end
			ST_HOLD: begin
				next_cnt = cnt + CNT_W'(1);
				if (hold_done) begin
					next_state = ST_RUN;
					next_cnt = '0;
				end
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_SYNC;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// decoded strap fields, straight from the capture flops
	logic [AEM_W-1:0] cap_aem;
	logic cap_cs2;
	logic cap_pci;
	logic cap_fast;
	assign cap_aem = sif.cap[AEM_LSB +: AEM_W];
	assign cap_cs2 = sif.cap[CS2W_POS];
	assign cap_pci = sif.cap[PCI_POS];
	assign cap_fast = sif.cap[FAST_POS];
	assign strap_capture_reg = sif.cap;
	assign latched_pinout_mode = cap_aem;
	assign boot_mode = sif.cap[BOOT_LSB +: BOOT_W];
	assign fast_boot = cap_fast;
	// multiplier only meaningful in fast boot, so mask it otherwise
	assign fast_boot_pll_mult = cap_fast ? sif.cap[PLL_LSB +: PLL_W] : '0;
	assign little_endian = sif.cap[ENDIAN_POS];
	assign pci_enable_field = cap_pci;
	assign pci_pulls_enable = !cap_pci;
	assign host_boot_pci = cap_pci;

	// software pinout field: seeded during hold, writable in run
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinout_mode <= AEM_NONE;
		end else if (holding) begin
			pinout_mode <= cap_aem;
		end else if (running && pinout_mode_wr) begin
			pinout_mode <= pinout_mode_wdata;
		end
	end

	// chip-select widths; cs2 seeded from its strap, others seeded at 8
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs2_width <= WIDTH_8;
		end else if (holding) begin
			cs2_width <= cap_cs2 ? WIDTH_16 : WIDTH_8;
		end else if (running && cs2_width_wr) begin
			cs2_width <= cs2_width_wdata;
		end
	end

	for (genvar c = 0; c < NUM_OTHER_CS; c++) begin : g_cs
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				cs_width[c] <= WIDTH_8;
			end else if (holding) begin
				cs_width[c] <= WIDTH_8;
			end else if (running && cs_width_wr[c]) begin
				cs_width[c] <= cs_width_wdata[c];
			end
		end
	end

	// memory module power default; power controller may change it later
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			held_in_soft_reset <= 1'h1;
		end else if (holding) begin
			held_in_soft_reset <= (cap_aem == AEM_NONE);
		end else if (running && mem_power_wr) begin
			held_in_soft_reset <= !mem_power_enable_wdata;
		end
	end

	// pad ownership: pinout mode alone picks memory or gpio per sub-block;
	// it feeds no control of the memory interface itself
	logic [2:0] owned_subs;
	logic [PAD_W-1:0] mem_owns;
	assign owned_subs = mem_owned_subs(pinout_mode);

	for (genvar p = 0; p < PAD_W; p++) begin : g_pad
		localparam logic [1:0] SUB = sub_block_of(p);
		localparam int BIT = (SUB == 2'h3) ? 2 : int'(SUB);
		assign mem_owns[p] = owned_subs[BIT];
		// nothing drives the pad until global reset is over
		assign pad_oe[p] = running && (mem_owns[p] ? mem_oe[p] : gpio_oe[p]);
		assign pad_out[p] = running && (mem_owns[p] ? mem_out[p] : gpio_out[p]);
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_captured;
		(state == ST_CAPTURE) ##1 holding;
	endsequence

	sequence s_run_entry;
		holding ##1 running;
	endsequence

	// the last synchroniser cycle, after which the strobe must follow
	sequence s_settled;
		(state == ST_SYNC) && sync_done;
	endsequence

	// two run cycles in a row, so a sampled history is available
	sequence s_steady_run;
		running && $past(running);
	endsequence

	a_hiz_until_run: assert property (!running |-> pad_oe == '0)
		else $error("strap pad driven before global reset ended");
	a_hold_length: assert property (s_captured |-> ##(HOLD_DLY - 1) holding ##1 running)
		else $error("global reset hold has wrong length");
	a_cs2_default: assert property (s_run_entry |-> cs2_width == cap_cs2)
		else $error("cs2 width default not taken from strap");
	a_cs2_write: assert property (running && cs2_width_wr |=> cs2_width == $past(cs2_width_wdata))
		else $error("cs2 width write not applied");
	a_other_cs_8bit: assert property (s_run_entry |-> cs_width == '0)
		else $error("other chip-select not 8-bit after reset");
	a_pinout_seed: assert property (s_run_entry |-> pinout_mode == latched_pinout_mode)
		else $error("pinout mode not seeded from strap");
	a_latched_kept: assert property (running && $past(running) |-> $stable(strap_capture_reg))
		else $error("captured straps changed after reset");
	a_power_default: assert property (s_run_entry |-> held_in_soft_reset == (cap_aem == AEM_NONE))
		else $error("memory power default wrong");
	a_pci_readonly: assert property (running && pci_field_wr |=> $stable(pci_enable_field))
		else $error("pci enable field changed by write");
	a_pll_masked: assert property (!fast_boot |-> fast_boot_pll_mult == '0)
		else $error("pll multiplier visible without fast boot");
	a_pulls_follow: assert property (pci_pulls_enable != pci_enable_field)
		else $error("pci pulls do not follow strap");
	a_gpio_when_none: assert property (running && pinout_mode == AEM_NONE |-> pad_oe == gpio_oe)
		else $error("gpio does not own pads in pinout mode zero");

	// one capture strobe once the synchroniser has settled,
	// then nothing may move the captured straps until the next reset
	a_capture_step: assert property (s_settled |=> sif.capture ##1 holding)
		else $error("capture strobe not issued after synchroniser settled");
	a_capture_load: assert property (sif.capture |=> sif.cap == $past(u_sampler.sync))
		else $error("capture register did not load the synchronised straps");
	a_hold_cap_kept: assert property (holding && $past(holding) |-> $stable(sif.cap))
		else $error("captured straps moved during global reset hold");
	a_run_sticky: assert property (running |=> running)
		else $error("left run state without a reset");
	a_endian_fixed: assert property (s_steady_run |-> $stable(little_endian))
		else $error("endianness changed after reset");
	a_boot_fixed: assert property (s_steady_run |-> $stable(boot_mode))
		else $error("boot mode changed after reset");
	a_fast_fixed: assert property (s_steady_run |-> $stable(fast_boot))
		else $error("fast boot changed after reset");
	a_pci_fixed: assert property (s_steady_run |-> $stable(pci_enable_field))
		else $error("pci enable field changed after reset");

	// defaults reload every hold cycle, so any later hold cycle shows them;
	// with a one-cycle hold these checks never start
	a_seed_hold: assert property (holding && $past(holding) |-> pinout_mode == cap_aem)
		else $error("pinout mode not seeded during hold");
	a_cs2_hold: assert property (holding && $past(holding) |-> cs2_width == cap_cs2)
		else $error("cs2 width not seeded during hold");
	a_power_hold: assert property (holding && $past(holding) |->
		held_in_soft_reset == (cap_aem == AEM_NONE))
		else $error("memory power state not seeded during hold");
	a_other_hold: assert property (holding && $past(holding) |-> cs_width == '0)
		else $error("other chip-select not 8-bit during hold");

	// software writes land one cycle after they are taken
	a_pinout_write: assert property (running && pinout_mode_wr |=>
		pinout_mode == $past(pinout_mode_wdata))
		else $error("pinout mode write not applied");
	a_latched_on_wr: assert property (running && pinout_mode_wr |=>
		$stable(latched_pinout_mode))
		else $error("latched pinout mode moved on a write");
	a_cs_write: assert property (running && cs_width_wr[0] |=>
		cs_width[0] == $past(cs_width_wdata[0]))
		else $error("chip-select width write not applied");
	a_cs_unwritten: assert property (running && !cs_width_wr[0] |=> $stable(cs_width[0]))
		else $error("unwritten chip-select width moved");
	a_power_write: assert property (running && mem_power_wr |=>
		held_in_soft_reset == !$past(mem_power_enable_wdata))
		else $error("memory power write not applied");

	// pad ownership at both ends of the pinout range, and idle pads
	a_gpio_out_none: assert property (running && pinout_mode == AEM_NONE |->
		pad_out == gpio_out)
		else $error("gpio does not drive pads in pinout mode zero");
	a_mem_owns_all: assert property (running && pinout_mode >= 3'h3 |->
		pad_oe == mem_oe)
		else $error("memory interface does not own every pad");
	a_mem_out_all: assert property (running && pinout_mode >= 3'h3 |->
		pad_out == mem_out)
		else $error("memory interface does not drive every pad");
	a_pad_out_idle: assert property (!running |-> pad_out == '0)
		else $error("strap pad value driven before global reset ended");
	a_pll_shown: assert property (fast_boot |->
		fast_boot_pll_mult == sif.cap[PLL_LSB +: PLL_W])
		else $error("pll multiplier hidden in fast boot");
endmodule

//--- sim/strap_board_model.sv
// board strap resistors and pad wire resolution for the strap latch
`timescale 1ns/1ps
module strap_board_model
	import strap_cfg_pkg::*;
(
	input wire logic [PAD_W-1:0] strap_level,
	input wire logic [PAD_W-1:0] pad_out,
	input wire logic [PAD_W-1:0] pad_oe,
	output logic [PAD_W-1:0] pad_in
);
	// a released pad settles to its strap resistor, a driven pad shows the driver
	// the bench holds strap_level steady for the whole reset interval
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & strap_level);
endmodule

//--- sim/test_strap_cfg_latch.sv
// self-checking bench for the reset strap configuration latch
`timescale 1ns/1ps
module test_strap_cfg_latch;
	import strap_cfg_pkg::*;
	// short global reset hold keeps the run brief
	localparam int HOLD = 2;
	localparam int WATCHDOG_NS = 2000 * 5;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [PAD_W-1:0] strap_level = '0;
	logic [PAD_W-1:0] pad_in, pad_out, pad_oe;
	logic pci_enable_strap = 1'b0;
	logic [PAD_W-1:0] gpio_out = 13'h1555;
	logic [PAD_W-1:0] gpio_oe = 13'h1fff;
	logic [PAD_W-1:0] mem_out = 13'h0aaa;
	logic [PAD_W-1:0] mem_oe = 13'h0f0f;
	logic pinout_mode_wr = 1'b0, pci_field_wr = 1'b0, pci_field_wdata = 1'b0;
	logic [AEM_W-1:0] pinout_mode_wdata = '0;
	logic cs2_width_wr = 1'b0, cs2_width_wdata = 1'b0;
	logic [2:0] cs_width_wr = '0, cs_width_wdata = '0;
	logic mem_power_wr = 1'b0, mem_power_enable_wdata = 1'b0;
	logic [CAP_W-1:0] strap_capture_reg;
	logic [AEM_W-1:0] latched_pinout_mode, pinout_mode;
	logic pci_enable_field, cs2_width, held_in_soft_reset, little_endian;
	logic [2:0] cs_width;
	logic pci_pulls_enable, host_boot_pci, fast_boot, global_reset_done;
	logic [BOOT_W-1:0] boot_mode;
	logic [PLL_W-1:0] fast_boot_pll_mult;
	int n_fail = 0;
	int n_compared = 0;

	// 200 MHz core clock
	always #2.5 core_clk = ~core_clk;

	strap_cfg_latch #(.NUM_OTHER_CS(3), .HOLD_CYCLES(HOLD)) dut (.core_clk, .rst_b, .pad_in,
		.pad_out, .pad_oe, .pci_enable_strap, .gpio_out, .gpio_oe, .mem_out, .mem_oe,
		.pinout_mode_wr, .pinout_mode_wdata, .pci_field_wr, .pci_field_wdata, .cs2_width_wr,
		.cs2_width_wdata, .cs_width_wr, .cs_width_wdata, .mem_power_wr,
		.mem_power_enable_wdata, .strap_capture_reg, .latched_pinout_mode, .pinout_mode,
		.pci_enable_field, .cs2_width, .cs_width, .held_in_soft_reset, .little_endian,
		.pci_pulls_enable, .host_boot_pci, .boot_mode, .fast_boot, .fast_boot_pll_mult,
		.global_reset_done);

	strap_board_model board (.strap_level, .pad_out, .pad_oe, .pad_in);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// reset with straps applied, then wait for the run state under a bound
	task automatic boot(input logic [CAP_W-1:0] s);
		int i;
		@(negedge core_clk);
		rst_b = 1'b0;
		strap_level = s[PAD_W-1:0];
		pci_enable_strap = s[PCI_POS];
		repeat (16) @(negedge core_clk);
		chk("pad_oe in reset", '0, pad_oe);
		rst_b = 1'b1;
		for (i = 0; i < 40 && global_reset_done !== 1'b1; i++) begin
			chk("pad_oe before run", '0, pad_oe);
			@(negedge core_clk);
		end
		chk("run delay", 3 + HOLD, i);
	endtask

	// every captured field and every seeded default
	task automatic check_defaults(input logic [CAP_W-1:0] s);
		chk("capture", s, strap_capture_reg);
		chk("latched mode", s[10:8], latched_pinout_mode);
		chk("pinout mode", s[10:8], pinout_mode);
		chk("cs2 width", s[CS2W_POS], cs2_width);
		chk("cs width", '0, cs_width);
		chk("soft reset", s[10:8] == 3'h0, held_in_soft_reset);
		chk("endian", s[ENDIAN_POS], little_endian);
		chk("pulls", !s[PCI_POS], pci_pulls_enable);
		chk("pci boot", s[PCI_POS], host_boot_pci);
		chk("pci field", s[PCI_POS], pci_enable_field);
		chk("boot mode", s[3:0], boot_mode);
		chk("fast boot", s[FAST_POS], fast_boot);
		chk("pll mult", s[FAST_POS] ? s[7:5] : 3'h0, fast_boot_pll_mult);
	endtask

	// one cycle of simultaneous software writes while the straps change under the run
	task automatic sw_writes(input logic [CAP_W-1:0] s);
		@(negedge core_clk);
		strap_level = ~s[PAD_W-1:0];
		gpio_oe = '0;
		mem_oe = '0;
		pinout_mode_wr = 1'b1;
		pinout_mode_wdata = 3'h2;
		cs2_width_wr = 1'b1;
		cs2_width_wdata = ~s[CS2W_POS];
		cs_width_wr = 3'h5;
		cs_width_wdata = 3'h7;
		pci_field_wr = 1'b1;
		pci_field_wdata = ~s[PCI_POS];
		mem_power_wr = 1'b1;
		mem_power_enable_wdata = 1'b0;
		@(negedge core_clk);
		{pinout_mode_wr, cs2_width_wr, cs_width_wr, pci_field_wr, mem_power_wr} = '0;
		chk("pinout write", 3'h2, pinout_mode);
		chk("latched kept", s[10:8], latched_pinout_mode);
		chk("cs2 write", !s[CS2W_POS], cs2_width);
		chk("cs write", 3'h5, cs_width);
		chk("pci ignored", s[PCI_POS], pci_enable_field);
		chk("power write", 1'b1, held_in_soft_reset);
		chk("capture held", s, strap_capture_reg);
	endtask

	// pad ownership per pinout mode, groups 0-3, 4-7, 8-12
	task automatic pad_mux();
		logic [PAD_W-1:0] m;
		gpio_oe = 13'h1fff;
		mem_oe = 13'h0f0f;
		for (int md = 0; md < 8; md++) begin
			@(negedge core_clk);
			pinout_mode_wr = 1'b1;
			pinout_mode_wdata = md[2:0];
			@(negedge core_clk);
			pinout_mode_wr = 1'b0;
			m = (md >= 1 ? 13'h000f : 13'h0) | (md >= 2 ? 13'h00f0 : 13'h0);
			m = m | (md >= 3 ? 13'h1f00 : 13'h0);
			chk("pad out", (mem_out & m) | (gpio_out & ~m), pad_out);
			chk("pad oe", (mem_oe & m) | (gpio_oe & ~m), pad_oe);
			chk("module kept", 1'b1, held_in_soft_reset);
		end
	endtask

	// main sequence
	initial begin
		boot(14'h00e5);
		check_defaults(14'h00e5);
		boot(14'h3d9a);
		check_defaults(14'h3d9a);
		sw_writes(14'h3d9a);
		pad_mux();
		stop_test();
	end

	// watchdog cuts a hang short
	initial begin
		#WATCHDOG_NS;
		n_fail++;
		stop_test();
	end
endmodule
